// File: rtl/uedf_cfg.svh
`ifndef UEDF_CFG_SVH
`define UEDF_CFG_SVH
// command codes
`define UEDF_CMD_SEL_BASE 8'h00
`define UEDF_CMD_LTS_BASE 8'h40
`define UEDF_CMD_EPST_BASE 8'h80
`define UEDF_CMD_RDBUF 8'hf0
`define UEDF_CMD_CLRBUF 8'hf2
`define UEDF_CMD_IRQ 8'hf4
`define UEDF_CMD_VALBUF 8'hfa
`define UEDF_NUM_EP 6
`define UEDF_MAX_RD 8'd130
// interrupt source bit positions
`define UEDF_IRQ_BUSRST 6
`define UEDF_IRQ_SUSP 7
// status byte fields
`define UEDF_ST_OK 0
`define UEDF_ST_SETUP 5
`define UEDF_ST_TOGGLE 6
`define UEDF_ST_NOTREAD 7
`define UEDF_SOF_MISS 2'd3
// buffer layout
`define UEDF_HDR_LEN 8'd2
`define UEDF_LEN_OFS 8'd1
`endif

// File: rtl/uedf_pkg.sv
package uedf_pkg;
    typedef enum logic [3:0] {
        UEDF_ERR_NONE = 4'h0,
        UEDF_ERR_PIDENC = 4'h1,
        UEDF_ERR_PIDUNK = 4'h2,
        UEDF_ERR_UNEXP = 4'h3,
        UEDF_ERR_TOKCRC = 4'h4,
        UEDF_ERR_DATCRC = 4'h5,
        UEDF_ERR_TIMEOUT = 4'h6,
        UEDF_ERR_EOP = 4'h8,
        UEDF_ERR_NAK = 4'h9,
        UEDF_ERR_STALL = 4'ha,
        UEDF_ERR_OVF = 4'hb,
        UEDF_ERR_STUFF = 4'hd,
        UEDF_ERR_TOGGLE = 4'hf
    } uedf_err_type;
    typedef enum logic [4:0] {
        UEDF_CTX_NONE = 5'h01,
        UEDF_CTX_SEL = 5'h02,
        UEDF_CTX_LTS = 5'h04,
        UEDF_CTX_BUF = 5'h08,
        UEDF_CTX_IRQ = 5'h10
    } uedf_ctx_type;
endpackage

// File: rtl/uedf_ep_status.sv
`timescale 1ns/100ps
`include "uedf_cfg.svh"
module uedf_ep_status
    import uedf_pkg::*;
#(
    parameter bit IS_IN = 1'b0
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic txn_in,
    input wire logic txn_ok_in,
    input wire logic txn_data1_in,
    input wire logic txn_setup_in,
    input wire logic [3:0] txn_err_in,
    input wire logic read_in,
    output logic [7:0] status_out,
    output logic irq_out
);
    logic unread_r;
    // =========================================
    // last transaction status
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_out <= 8'h00;
            unread_r <= 1'b0;
        end else if (txn_in) begin
            // new event overwrites, even if unread; event beats read clear
            status_out[`UEDF_ST_NOTREAD] <= unread_r;
            status_out[`UEDF_ST_TOGGLE] <= txn_data1_in;
            status_out[`UEDF_ST_SETUP] <= IS_IN ? 1'b0 : txn_setup_in;
            status_out[4:1] <= (txn_err_in == 4'h7) ? 4'h0 : txn_err_in;
            status_out[`UEDF_ST_OK] <= txn_ok_in;
            unread_r <= 1'b1;
        end else if (read_in) begin
            status_out <= 8'h00;
            unread_r <= 1'b0;
        end
    end
    // endpoint interrupt only cleared by status read
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else if (txn_in) begin
            irq_out <= 1'b1;
        end else if (read_in) begin
            irq_out <= 1'b0;
        end
    end
endmodule

// File: rtl/uedf_cmd.sv
`timescale 1ns/100ps
`include "uedf_cfg.svh"
module uedf_cmd
    import uedf_pkg::*;
#(
    parameter int NUM_EP = `UEDF_NUM_EP,
    parameter int BUF_DEPTH = 130
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // microcontroller side
    input wire logic cmd_wr_in,
    input wire logic data_wr_in,
    input wire logic data_rd_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    output logic irq_out,
    input wire logic sof_irq_mode_in,
    // usb engine side
    input wire logic sof_in,
    input wire logic sof_tick_in,
    input wire logic bus_reset_in,
    input wire logic txn_in,
    input wire logic [2:0] txn_ep_in,
    input wire logic txn_ok_in,
    input wire logic txn_data1_in,
    input wire logic txn_setup_in,
    input wire logic [3:0] txn_err_in,
    input wire logic rx_wr_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_eop_in,
    input wire logic dma_rd_in,
    input wire logic in_sent_in,
    output logic [NUM_EP-1:0] buf_full_out,
    output logic suspend_out,
    output logic addr_zero_out
);
    // pointers and length byte are one byte wide, so depth stays below 256
    if (NUM_EP < 1 || NUM_EP > 6 || BUF_DEPTH < 3 || BUF_DEPTH > 255) begin : g_bad_param
        $error("uedf_cmd: unsupported parameters");
    end
    // =========================================
    // reset synchroniser
    logic rst_s1_r, rst_n_r;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end
    // =========================================
    // command context
    uedf_ctx_type ctx_r;
    logic [2:0] ep_r;
    // buffer endpoint survives status reads so buffer access can be interleaved
    logic [2:0] buf_ep_r;
    logic [7:0] rd_cnt_r;
    logic [7:0] ptr_r [NUM_EP];
    logic irq_byte_r;
    logic [7:0] wcmd;
    assign wcmd = wdata_in;
    always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctx_r <= UEDF_CTX_NONE;
            ep_r <= 3'h0;
            buf_ep_r <= 3'h0;
        end else if (cmd_wr_in) begin
            ctx_r <= UEDF_CTX_NONE;
            if (wcmd < 8'(NUM_EP)) begin
                ctx_r <= UEDF_CTX_SEL;
                ep_r <= wcmd[2:0];
                buf_ep_r <= wcmd[2:0];
            end else if (wcmd >= `UEDF_CMD_LTS_BASE && wcmd < `UEDF_CMD_LTS_BASE + 8'(NUM_EP)) begin
                ctx_r <= UEDF_CTX_LTS;
                ep_r <= wcmd[2:0];
            end else if (wcmd == `UEDF_CMD_RDBUF) begin
                ctx_r <= UEDF_CTX_BUF;
            end else if (wcmd == `UEDF_CMD_IRQ) begin
                ctx_r <= UEDF_CTX_IRQ;
            end
        end else if (data_rd_in && (ctx_r == UEDF_CTX_SEL || ctx_r == UEDF_CTX_LTS)) begin
            ctx_r <= UEDF_CTX_NONE; // single byte transactions
        end
    end
    // =========================================
    // endpoint buffer memory
    logic [7:0] mem_r [NUM_EP][BUF_DEPTH];
    logic [7:0] rx_ptr_r [NUM_EP];
    logic [2:0] sel_ep;
    assign sel_ep = txn_ep_in < 3'(NUM_EP) ? txn_ep_in : 3'h0;
    always_ff @(posedge clk_sys_in) begin
        if (rx_wr_in && !buf_full_out[sel_ep] && rx_ptr_r[sel_ep] < 8'(BUF_DEPTH)) begin
            mem_r[sel_ep][rx_ptr_r[sel_ep]] <= rx_data_in;
        end else if (rx_eop_in) begin
            mem_r[sel_ep][`UEDF_LEN_OFS] <= rx_ptr_r[sel_ep] - `UEDF_HDR_LEN;
        end
    end
    // receive write pointer; payload begins after header
    always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            for (int i = 0; i < NUM_EP; i++) begin
                rx_ptr_r[i] <= `UEDF_HDR_LEN;
            end
        end else if (rx_wr_in && !buf_full_out[sel_ep]) begin
            rx_ptr_r[sel_ep] <= rx_ptr_r[sel_ep] + 8'h01;
        end else if (rx_eop_in) begin
            rx_ptr_r[sel_ep] <= `UEDF_HDR_LEN;
        end
    end
    // buffer full flags
    always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            buf_full_out <= '0;
        end else begin
            for (int i = 0; i < NUM_EP; i++) begin
                // hardware set wins over firmware clear
                if (rx_eop_in && sel_ep == 3'(i)) begin
                    buf_full_out[i] <= 1'b1;
                end else if (cmd_wr_in && wcmd == `UEDF_CMD_VALBUF && buf_ep_r == 3'(i)) begin
                    buf_full_out[i] <= 1'b1;
                end else if (cmd_wr_in && wcmd == `UEDF_CMD_CLRBUF && buf_ep_r == 3'(i)) begin
                    buf_full_out[i] <= 1'b0;
                end else if (in_sent_in && sel_ep == 3'(i)) begin
                    buf_full_out[i] <= 1'b0;
                end
            end
        end
    end
    // =========================================
    // buffer pointer
    always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            for (int i = 0; i < NUM_EP; i++) begin
                ptr_r[i] <= 8'h00;
            end
            rd_cnt_r <= 8'h00;
        end else if (cmd_wr_in && wcmd < 8'(NUM_EP)) begin
            ptr_r[wcmd[2:0]] <= 8'h00;
            rd_cnt_r <= 8'h00;
        end else if (cmd_wr_in) begin
            rd_cnt_r <= 8'h00;
        end else if (dma_rd_in) begin
            // dma jumps over the two header bytes
            if (ptr_r[buf_ep_r] < `UEDF_HDR_LEN) begin
                ptr_r[buf_ep_r] <= `UEDF_HDR_LEN + 8'h01;
            end else begin
                ptr_r[buf_ep_r] <= ptr_r[buf_ep_r] + 8'h01;
            end
        end else if (data_rd_in && ctx_r == UEDF_CTX_BUF && rd_cnt_r < `UEDF_MAX_RD) begin
            ptr_r[buf_ep_r] <= ptr_r[buf_ep_r] + 8'h01;
            rd_cnt_r <= rd_cnt_r + 8'h01;
        end
    end
    // =========================================
    // per endpoint status
    logic [7:0] st_w [NUM_EP];
    logic [NUM_EP-1:0] ep_irq_w;
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : g_ep
            uedf_ep_status #(
                .IS_IN(1'(g % 2))
            ) u_st (
                .clk_sys_in(clk_sys_in),
                .rst_n_in(rst_n_r),
                .txn_in(txn_in && txn_ep_in == 3'(g)),
                .txn_ok_in(txn_ok_in),
                .txn_data1_in(txn_data1_in),
                .txn_setup_in(txn_setup_in),
                .txn_err_in(txn_err_in),
                .read_in(data_rd_in && ctx_r == UEDF_CTX_LTS && ep_r == 3'(g)),
                .status_out(st_w[g]),
                .irq_out(ep_irq_w[g])
            );
        end
    endgenerate
    // =========================================
    // suspend and bus reset sources
    logic [1:0] miss_r;
    logic susp_chg_r, bus_rst_r, sof_pend_r;
    wire irq_rd_done = data_rd_in && ctx_r == UEDF_CTX_IRQ && irq_byte_r;
    always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            miss_r <= 2'd0;
            suspend_out <= 1'b0;
            susp_chg_r <= 1'b0;
        end else begin
            if (sof_in) begin
                miss_r <= 2'd0;
                if (suspend_out) begin
                    suspend_out <= 1'b0;
                    susp_chg_r <= 1'b1;
                end else if (irq_rd_done) begin
                    susp_chg_r <= 1'b0;
                end
            end else if (sof_tick_in && !suspend_out) begin
                if (miss_r == `UEDF_SOF_MISS - 2'd1) begin
                    suspend_out <= 1'b1;
                    susp_chg_r <= 1'b1;
                end else begin
                    miss_r <= miss_r + 2'd1;
                    if (irq_rd_done) susp_chg_r <= 1'b0;
                end
            end else if (irq_rd_done) begin
                susp_chg_r <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            bus_rst_r <= 1'b0;
            addr_zero_out <= 1'b1;
        end else if (bus_reset_in) begin
            bus_rst_r <= 1'b1;
            addr_zero_out <= 1'b1;
        end else if (irq_rd_done) begin
            bus_rst_r <= 1'b0;
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sof_pend_r <= 1'b0;
        end else if (sof_in && sof_irq_mode_in) begin
            sof_pend_r <= 1'b1;
        end else if (irq_rd_done) begin
            sof_pend_r <= 1'b0;
        end
    end
    // =========================================
    // interrupt source word and pin
    logic [15:0] isrc_w;
    always_comb begin
        isrc_w = 16'h0000;
        isrc_w[NUM_EP-1:0] = ep_irq_w;
        isrc_w[`UEDF_IRQ_BUSRST] = bus_rst_r;
        isrc_w[`UEDF_IRQ_SUSP] = susp_chg_r;
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= (|isrc_w) || sof_pend_r;
        end
    end
    // =========================================
    // read data
    always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            irq_byte_r <= 1'b0;
        end else if (cmd_wr_in) begin
            irq_byte_r <= 1'b0;
        end else if (data_rd_in && ctx_r == UEDF_CTX_IRQ) begin
            irq_byte_r <= 1'b1;
        end
    end
    // data presented combinationally then registered on the read strobe that fetches it
    logic [7:0] rd_nxt;
    always_comb begin
        rd_nxt = 8'h00;
        unique case (ctx_r)
            UEDF_CTX_SEL: rd_nxt = {7'h00, buf_full_out[buf_ep_r]};
            UEDF_CTX_LTS: rd_nxt = st_w[ep_r];
            UEDF_CTX_BUF: rd_nxt = mem_r[buf_ep_r][ptr_r[buf_ep_r]];
            UEDF_CTX_IRQ: rd_nxt = irq_byte_r ? isrc_w[15:8] : isrc_w[7:0];
            default: rd_nxt = 8'h00;
        endcase
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdata_out <= 8'h00;
        end else if (data_rd_in) begin
            rdata_out <= rd_nxt;
        end
    end
endmodule

// File: bench/uedf_cmd_assertions.sv
`timescale 1ns/100ps
// ========
// port checks
module uedf_cmd_check
    import uedf_pkg::*;
#(
    parameter int NUM_EP = 6,
    parameter int BUF_DEPTH = 130
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic cmd_wr_in,
    input wire logic data_rd_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] rdata_out,
    input wire logic irq_out,
    input wire logic sof_tick_in,
    input wire logic bus_reset_in,
    input wire logic txn_in,
    input wire logic [2:0] txn_ep_in,
    input wire logic rx_eop_in,
    input wire logic in_sent_in,
    input wire logic [NUM_EP-1:0] buf_full_out,
    input wire logic suspend_out,
    input wire logic addr_zero_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    logic [2:0] sel_r;
    // endpoint that buffer commands act on
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sel_r <= 3'h0;
        end else if (cmd_wr_in && wdata_in < 8'h06) begin
            sel_r <= wdata_in[2:0];
        end
    end
    a_addr_zero_kept: assert property (addr_zero_out)
        else $error("address not zero");
    a_busrst_irq_up: assert property (bus_reset_in |-> ##[1:3] irq_out)
        else $error("no irq after bus reset");
    a_txn_irq_up: assert property (txn_in && txn_ep_in < 3'h6 |-> ##[1:3] irq_out)
        else $error("no irq after transaction");
    a_susp_change_irq: assert property ($changed(suspend_out) |-> ##[0:2] irq_out)
        else $error("no irq on suspend change");
    a_susp_after_miss: assert property ($rose(suspend_out) |->
        $past(sof_tick_in) || $past(sof_tick_in, 2) || $past(sof_tick_in, 3))
        else $error("suspend without missed frame");
    // reads only move the answer; commands leave it alone
    a_rdata_held: assert property (!data_rd_in && !$past(data_rd_in) && !$past(data_rd_in, 2)
        |=> $stable(rdata_out))
        else $error("read data moved");
    a_valid_sets_full: assert property (cmd_wr_in && wdata_in == 8'hfa
        |-> ##[1:2] buf_full_out[sel_r])
        else $error("validate did not set full");
    a_clear_empties: assert property (cmd_wr_in && wdata_in == 8'hf2 && !rx_eop_in
        |-> ##[1:2] !buf_full_out[sel_r])
        else $error("clear did not free buffer");
    a_sent_empties: assert property (in_sent_in && txn_ep_in == 3'h3
        |-> ##[1:2] !buf_full_out[3])
        else $error("sent buffer still full");
    c_bus_reset: cover property (bus_reset_in);
    c_suspend: cover property ($rose(suspend_out));
    c_buf_read: cover property (cmd_wr_in && wdata_in == 8'hf0 ##[1:4] data_rd_in);
endmodule

// File: bench/uedf_mcu_model.sv
`timescale 1ns/100ps
// ========
// microcontroller on the command bus
module uedf_mcu_model (
    input wire logic clk_sys_in,
    input wire logic [7:0] rdata_in,
    output logic cmd_wr_out,
    output logic data_wr_out,
    output logic data_rd_out,
    output logic [7:0] wdata_out
);
    initial begin
        {cmd_wr_out, data_wr_out, data_rd_out, wdata_out} = 11'h000;
    end
    // each command byte opens a fresh context for later reads
    task automatic send_cmd(input logic [7:0] c);
        @(posedge clk_sys_in);
        cmd_wr_out <= 1'b1;
        wdata_out <= c;
        @(posedge clk_sys_in);
        cmd_wr_out <= 1'b0;
        wdata_out <= ~c; // no stale byte left on the bus
    endtask
    task automatic get(output logic [7:0] d);
        @(posedge clk_sys_in);
        data_rd_out <= 1'b1;
        @(posedge clk_sys_in);
        data_rd_out <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        d = rdata_in;
    endtask
endmodule

// File: bench/usb_endpoint_data_flow_commands_test.sv
`timescale 1ns/100ps
// ========
// command interpreter bench
module usb_endpoint_data_flow_commands_test;
    logic clk_sys_in, resetn_in, sof_irq_mode_in, txn_in, txn_ok_in, txn_data1_in;
    logic txn_setup_in, rx_wr_in, rx_eop_in, cmd_wr, data_wr, data_rd, irq_out;
    logic suspend_out, addr_zero_out, ok, d1, su;
    logic [4:0] ev_v;
    logic [2:0] txn_ep_in, ep;
    logic [3:0] txn_err_in, e;
    logic [7:0] rx_data_in, wdata, rdata, v;
    logic [5:0] buf_full_out;
    logic [7:0] pl [0:7];
    logic [3:0] errs [0:12];
    logic [31:0] seed = 32'h00002349;
    int n_errors = 0;
    int check_count = 0;
    int n;
    uedf_cmd uedf_cmd_i (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cmd_wr_in(cmd_wr),
        .data_wr_in(data_wr), .data_rd_in(data_rd), .wdata_in(wdata), .rdata_out(rdata),
        .irq_out(irq_out), .sof_irq_mode_in(sof_irq_mode_in), .sof_in(ev_v[0]),
        .sof_tick_in(ev_v[1]), .bus_reset_in(ev_v[2]), .txn_in(txn_in),
        .txn_ep_in(txn_ep_in), .txn_ok_in(txn_ok_in), .txn_data1_in(txn_data1_in),
        .txn_setup_in(txn_setup_in), .txn_err_in(txn_err_in), .rx_wr_in(rx_wr_in),
        .rx_data_in(rx_data_in), .rx_eop_in(rx_eop_in), .dma_rd_in(ev_v[3]),
        .in_sent_in(ev_v[4]), .buf_full_out(buf_full_out), .suspend_out(suspend_out),
        .addr_zero_out(addr_zero_out)
    );
    uedf_mcu_model uedf_mcu_model_i (
        .clk_sys_in(clk_sys_in), .rdata_in(rdata), .cmd_wr_out(cmd_wr),
        .data_wr_out(data_wr), .data_rd_out(data_rd), .wdata_out(wdata)
    );
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    // setup flag only for control (even) endpoints
    function automatic logic [7:0] st(logic d, logic s, logic [3:0] c, logic k, logic [2:0] p);
        return {1'b0, d, s & ~p[0], (c == 4'h7) ? 4'h0 : c, k};
    endfunction
    task automatic chk(input logic [7:0] s, input logic [7:0] x);
        check_count++;
        if (s !== x) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic conclude();
        if (n_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic ev(input int k);
        @(posedge clk_sys_in);
        ev_v <= 5'h01 << k;
        @(posedge clk_sys_in);
        ev_v <= 5'h00;
    endtask
    task automatic txn(input logic [2:0] p, input logic k, input logic d, input logic s,
                       input logic [3:0] c);
        @(posedge clk_sys_in);
        txn_in <= 1'b1;
        {txn_ep_in, txn_ok_in, txn_data1_in, txn_setup_in, txn_err_in} <= {p, k, d, s, c};
        @(posedge clk_sys_in);
        txn_in <= 1'b0;
    endtask
    task automatic rx(input logic [2:0] p, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            @(posedge clk_sys_in);
            {rx_wr_in, txn_ep_in, rx_data_in} <= {1'b1, p, pl[i]};
        end
        @(posedge clk_sys_in);
        {rx_wr_in, rx_eop_in} <= 2'h1;
        @(posedge clk_sys_in);
        rx_eop_in <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] c);
        uedf_mcu_model_i.send_cmd(c);
    endtask
    task automatic cr(input logic [7:0] c, input logic [7:0] x);
        if (c != 8'h00) cmd(c);
        uedf_mcu_model_i.get(v);
        chk(v, x);
    endtask
    // interrupt word, low byte first
    task automatic irqw(input logic [7:0] lo);
        cr(8'hf4, lo);
        cr(8'h00, 8'h00);
    endtask
    task automatic flags(input logic [7:0] x);
        settle();
        chk({irq_out, suspend_out, buf_full_out}, x);
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        repeat (50000) @(posedge clk_sys_in);
        n_errors++;
        conclude();
    end
    initial begin
        resetn_in = 1'b0;
        {sof_irq_mode_in, txn_in, txn_ok_in, txn_data1_in, txn_setup_in} = 5'h00;
        {rx_wr_in, rx_eop_in, ev_v, txn_ep_in, txn_err_in, rx_data_in} = 22'h0;
        errs = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hd, 4'hf};
        repeat (2) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        flags(8'h00);
        chk({7'h00, addr_zero_out}, 8'h01);
        ev(2);
        flags(8'h80);
        irqw(8'h40);
        irqw(8'h00);
        ev(1);
        ev(1);
        flags(8'h00);
        ev(1);
        flags(8'hc0);
        irqw(8'h80);
        ev(0);
        flags(8'h80);
        irqw(8'h80);
        for (int i = 0; i < 16; i++) begin
            ep = 3'(i % 6);
            ok = (i >= 13);
            e = ok ? 4'h0 : errs[i];
            n = int'(rnd());
            {d1, su} = {ok & n[0], ok & n[1]};
            txn(ep, ok, d1, su, e);
            flags(8'h80);
            irqw(8'h01 << ep);
            irqw(8'h01 << ep);
            cr(8'h40 + {5'h00, ep}, st(d1, su, e, ok, ep));
            flags(8'h00);
        end
        txn(3'h1, 1'b1, 1'b1, 1'b0, 4'h0);
        txn(3'h1, 1'b1, 1'b1, 1'b0, 4'h0);
        cr(8'h41, 8'hc1);
        txn(3'h1, 1'b1, 1'b0, 1'b0, 4'h0);
        cr(8'h41, 8'h01);
        ev(0);
        flags(8'h00);
        n = 2 + int'(rnd()) % 7;
        for (int i = 0; i < 8; i++) begin
            pl[i] = rnd();
        end
        rx(3'h2, n);
        txn(3'h2, 1'b1, 1'b0, 1'b0, 4'h0);
        cr(8'h02, 8'h01);
        cmd(8'hf0);
        uedf_mcu_model_i.get(v);
        cr(8'h00, 8'(n));
        cr(8'h00, pl[0]);
        cr(8'h42, 8'h01);
        cr(8'hf0, pl[1]);
        cmd(8'h02);
        ev(3);
        cr(8'hf0, pl[1]);
        cmd(8'hf2);
        flags(8'h00);
        cmd(8'h03);
        cmd(8'hfa);
        settle();
        chk({2'h0, buf_full_out}, 8'h08);
        @(posedge clk_sys_in);
        txn_ep_in <= 3'h3;
        ev(4);
        settle();
        chk({2'h0, buf_full_out}, 8'h00);
        @(posedge clk_sys_in);
        sof_irq_mode_in <= 1'b1;
        ev(0);
        settle();
        chk({7'h00, irq_out}, 8'h01);
        conclude();
    end
endmodule
bind uedf_cmd uedf_cmd_check #(.NUM_EP(NUM_EP), .BUF_DEPTH(BUF_DEPTH)) uedf_cmd_check_i (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cmd_wr_in(cmd_wr_in),
    .data_rd_in(data_rd_in), .wdata_in(wdata_in), .rdata_out(rdata_out), .irq_out(irq_out),
    .sof_tick_in(sof_tick_in), .bus_reset_in(bus_reset_in), .txn_in(txn_in),
    .txn_ep_in(txn_ep_in), .rx_eop_in(rx_eop_in), .in_sent_in(in_sent_in),
    .buf_full_out(buf_full_out), .suspend_out(suspend_out), .addr_zero_out(addr_zero_out)
);
